/* File: src/fbs_pkg.sv */
// Shared constants, carriers and helpers for the flow-through burst SRAM port
`default_nettype none

package fbs_pkg;

   // Word organisation: each lane is eight data bits plus one parity bit
   localparam int BYTE_BITS = 8;
   localparam int LANE_BITS = 9;
   localparam int WIDE_LANES = 4;
   localparam int NARROW_LANES = 2;
   localparam int WIDE_ADDR_W = 19;
   localparam int NARROW_ADDR_W = 20;
   localparam int BURST_BITS = 2;

   // Values loaded at reset, and the sleep count loaded on sleep entry or exit
   localparam logic [1:0] BURST_ZERO = 2'h0;
   localparam logic [1:0] SLEEP_CNT_ZERO = 2'h0;
   localparam logic [1:0] SLEEP_CNT_FIRST = 2'h1;

   // Sleep entry and exit, in clock cycles
   localparam int SLEEP_ENTER_CYC = 2;
   localparam int SLEEP_EXIT_CYC = 2;
   localparam logic [1:0] SLEEP_ENTER_LAST = 2'(SLEEP_ENTER_CYC - 1);
   localparam logic [1:0] SLEEP_EXIT_LAST = 2'(SLEEP_EXIT_CYC - 1);

   // Strobes, burst advance and write controls sampled at each edge
   typedef struct packed {
      logic proc_strobe_n;
      logic ctrl_strobe_n;
      logic advance_n;
      logic all_write_n;
      logic lane_wr_en_n;
   } fbs_ctl_t;

   // The three chip selects
   typedef struct packed {
      logic sel1_n;
      logic sel2;
      logic sel3_n;
   } fbs_sel_t;

   // Sleep sequencer states
   typedef enum logic [3:0] {
      FBS_AWAKE = 4'h1,
      FBS_ENTER = 4'h2,
      FBS_ASLEEP = 4'h4,
      FBS_EXIT = 4'h8
   } fbs_sleep_t;

   // Low burst address bits from start and count
   function automatic logic [1:0] fbs_burst_addr(input logic [1:0] start,
                                                 input logic [1:0] cnt,
                                                 input logic interleave);
      fbs_burst_addr = interleave ? (start ^ cnt) : 2'(start + cnt);
   endfunction

endpackage

`default_nettype wire

/* File: src/fbs_burst_ctr.sv */
// Two-bit wraparound burst counter with interleaved or linear order
`default_nettype none

module fbs_burst_ctr
(
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic clk_en_in,
   input wire logic load_in,
   input wire logic [1:0] start_in,
   input wire logic step_in,
   input wire logic interleave_in,
   output logic [1:0] next_low_out,
   output logic [1:0] low_out
);

   logic [1:0] start;
   logic [1:0] cnt;
   logic [1:0] next_start;
   logic [1:0] next_cnt;

   // Load start, step or hold
   always_comb
   begin
      next_start = load_in ? start_in : start;
      next_cnt = load_in ? fbs_pkg::BURST_ZERO : (step_in ? 2'(cnt + 2'h1) : cnt);
   end

   // Count register
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_b_in)
      begin
         start <= fbs_pkg::BURST_ZERO;
         cnt <= fbs_pkg::BURST_ZERO;
      end
      else if (clk_en_in)
      begin
         start <= next_start;
         cnt <= next_cnt;
      end
   end

   // Address bits now and after this edge
   assign next_low_out = fbs_pkg::fbs_burst_addr(next_start, next_cnt, interleave_in);
   assign low_out = fbs_pkg::fbs_burst_addr(start, cnt, interleave_in);

   property p_order_step;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (clk_en_in && step_in && !load_in && $stable(interleave_in)) |=>
         (low_out == fbs_pkg::fbs_burst_addr($past(start), 2'($past(cnt) + 2'h1),
                                             interleave_in));
   endproperty
   a_order_step: assert property (p_order_step)
      else $error("burst step gave wrong address");

endmodule // fbs_burst_ctr

`default_nettype wire

/* File: src/fbs_mem.sv */
// Lane-writable storage array with registered read data
`default_nettype none

module fbs_mem
#(
   parameter int ADDR_W = fbs_pkg::WIDE_ADDR_W,
   parameter int LANES = fbs_pkg::WIDE_LANES
)
(
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic clk_en_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic rd_en_in,
   input wire logic [LANES-1:0] lane_we_in,
   input wire logic [LANES*fbs_pkg::LANE_BITS-1:0] wdata_in,
   output logic [LANES*fbs_pkg::LANE_BITS-1:0] rdata_out
);

   logic [LANES*fbs_pkg::LANE_BITS-1:0] mem [2**ADDR_W];

   // Lane writes, parity bit carried inside its own lane
   always_ff @(posedge sys_clk_in)
   begin
      if (clk_en_in)
      begin
         for (int i = 0; i < LANES; i++)
         begin
            if (lane_we_in[i])
            begin
               mem[addr_in][i*fbs_pkg::LANE_BITS +: fbs_pkg::LANE_BITS] <=
                  wdata_in[i*fbs_pkg::LANE_BITS +: fbs_pkg::LANE_BITS];
            end
         end
      end
   end

   // Read word registered at the addressing edge
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_b_in)
         rdata_out <= '0;
      else if (clk_en_in && rd_en_in)
         rdata_out <= mem[addr_in];
   end

endmodule // fbs_mem

`default_nettype wire

/* File: src/fbs_port.sv */
// Flow-through burst SRAM host port: strobes, burst control, lane writes, sleep
`default_nettype none

// Overview of operation
// - All synchronous inputs are taken at the rising clock edge.
// - A two-bit counter holds burst start and makes the following addresses.
// - Strap high selects interleaved order, strap low selects linear order.
// - A strobe with all selects active captures address and select levels.
// - Captured address low bits start the burst counter.
// - Both strobes low with primary select low: only the processor strobe counts.
// - Processor strobe ignored while primary select is high.
// - Selects need first and third low, second high; sampled only at loads.
// - Counter steps on each edge where advance is sampled low while selected and awake and no strobe is taken.
// - Global write low writes every lane regardless of lane controls.
// - Lane write enable low writes only lanes whose select is low.
// - Parity bits are plain data, written with their own lane.
// - Output enable low drives the data pins, high floats them.
// - Output enable is ignored on the first read after deselection.
// - Pins float during write data, first clock after deselect, and deselected.
// - Outputs show the word addressed at the previous read edge.
// - Bursts run two clocks for the first transfer, one for each next.
// - Sleep input high enters a low-power state keeping contents.
// - Built 36 or 18 bits wide, nine-bit lanes with parity.
// - Interleaved order XORs start with count; linear adds modulo four.
// - Processor-started write ignores write controls on its first edge.
// - Sleep entry and exit take two clocks; device kept deselected.

module fbs_port
#(
   parameter int LANES = fbs_pkg::WIDE_LANES,
   parameter int ADDR_W = fbs_pkg::WIDE_ADDR_W
)
(
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic clk_en_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic processor_addr_strobe_n_in,
   input wire logic controller_addr_strobe_n_in,
   input wire logic burst_advance_n_in,
   input wire logic chip_sel1_n_in,
   input wire logic chip_sel2_in,
   input wire logic chip_sel3_n_in,
   input wire logic all_lanes_write_n_in,
   input wire logic lane_write_enable_n_in,
   input wire logic [LANES-1:0] lane_select_n_in,
   input wire logic output_enable_n_in,
   input wire logic sleep_request_in,
   input wire logic burst_order_in,
   input wire logic [LANES*fbs_pkg::BYTE_BITS-1:0] dq_in,
   input wire logic [LANES-1:0] parity_io_in,
   output logic [LANES*fbs_pkg::BYTE_BITS-1:0] dq_out,
   output logic [LANES-1:0] parity_io_out,
   output logic dq_oe_out,
   output logic sleep_active_out
);

   localparam int WORD_W = LANES * fbs_pkg::LANE_BITS;
   // Only the two documented organisations are served
   if (!((LANES == fbs_pkg::WIDE_LANES) || (LANES == fbs_pkg::NARROW_LANES)))
   begin : g_bad_lanes
      $error("LANES must be 4 or 2");
   end
   if (ADDR_W <= fbs_pkg::BURST_BITS)
   begin : g_bad_addr
      $error("ADDR_W too small for burst group");
   end

   fbs_pkg::fbs_ctl_t ctl;
   fbs_pkg::fbs_sel_t sel;
   fbs_pkg::fbs_sleep_t sleep_state;
   fbs_pkg::fbs_sleep_t next_sleep_state;
   logic [1:0] sleep_cnt;
   logic [1:0] next_sleep_cnt;
   logic awake;
   logic chip_on;
   logic proc_take;
   logic ctrl_take;
   logic load;
   logic start;
   logic active;
   logic step;
   logic [LANES-1:0] wr_mask;
   logic wr_any;
   logic do_write;
   logic do_read;
   logic drive;
   logic [ADDR_W-1:0] addr_hi_reg;
   logic [ADDR_W-1:0] mem_addr;
   logic [1:0] burst_next_low;
   logic [1:0] burst_low;
   logic [WORD_W-1:0] wdata;
   logic [WORD_W-1:0] rdata;

   // Gather controls and selects into carriers
   assign ctl = '{proc_strobe_n: processor_addr_strobe_n_in, advance_n: burst_advance_n_in,
                  ctrl_strobe_n: controller_addr_strobe_n_in, all_write_n: all_lanes_write_n_in,
                  lane_wr_en_n: lane_write_enable_n_in};
   assign sel = '{sel1_n: chip_sel1_n_in, sel2: chip_sel2_in, sel3_n: chip_sel3_n_in};

   // Sleep sequencer next state
   always_comb
   begin
      next_sleep_state = sleep_state;
      next_sleep_cnt = sleep_cnt;
      unique case (sleep_state)
         fbs_pkg::FBS_AWAKE:
         begin
            if (sleep_request_in)
            begin
               next_sleep_state = fbs_pkg::FBS_ENTER;
               next_sleep_cnt = fbs_pkg::SLEEP_CNT_FIRST;
            end
         end
         fbs_pkg::FBS_ENTER:
         begin
            if (!sleep_request_in)
               next_sleep_state = fbs_pkg::FBS_AWAKE;
            else if (sleep_cnt == fbs_pkg::SLEEP_ENTER_LAST)
               next_sleep_state = fbs_pkg::FBS_ASLEEP;
            else
               next_sleep_cnt = 2'(sleep_cnt + 2'h1);
         end
         fbs_pkg::FBS_ASLEEP:
         begin
            if (!sleep_request_in)
            begin
               next_sleep_state = fbs_pkg::FBS_EXIT;
               next_sleep_cnt = fbs_pkg::SLEEP_CNT_FIRST;
            end
         end
         fbs_pkg::FBS_EXIT:
         begin
            if (sleep_request_in)
               next_sleep_state = fbs_pkg::FBS_ASLEEP;
            else if (sleep_cnt == fbs_pkg::SLEEP_EXIT_LAST)
               next_sleep_state = fbs_pkg::FBS_AWAKE;
            else
               next_sleep_cnt = 2'(sleep_cnt + 2'h1);
         end
         default:
         begin
            next_sleep_state = fbs_pkg::FBS_AWAKE;
            next_sleep_cnt = fbs_pkg::SLEEP_CNT_ZERO;
         end
      endcase
   end

   // Sleep sequencer registers
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_b_in)
      begin
         sleep_state <= fbs_pkg::FBS_AWAKE;
         sleep_cnt <= fbs_pkg::SLEEP_CNT_ZERO;
         sleep_active_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         sleep_state <= next_sleep_state;
         sleep_cnt <= next_sleep_cnt;
         sleep_active_out <= (next_sleep_state == fbs_pkg::FBS_ASLEEP) ||
                             (next_sleep_state == fbs_pkg::FBS_EXIT);
      end
   end

   // Strobe arbitration and select decode
   assign awake = (sleep_state == fbs_pkg::FBS_AWAKE);
   assign chip_on = !sel.sel1_n && sel.sel2 && !sel.sel3_n;
   assign proc_take = awake && !ctl.proc_strobe_n && !sel.sel1_n;
   assign ctrl_take = awake && !ctl.ctrl_strobe_n && !proc_take;
   assign load = proc_take || ctrl_take;
   assign start = load && chip_on;
   assign step = awake && active && !load && !ctl.advance_n;

   // Lane write mask: global write overrides lane controls
   always_comb
   begin
      if (!ctl.all_write_n)
         wr_mask = '1;
      else if (!ctl.lane_wr_en_n)
         wr_mask = ~lane_select_n_in;
      else
         wr_mask = '0;
   end
   assign wr_any = |wr_mask;

   // Access kind at this edge
   assign do_write = awake && wr_any && ((ctrl_take && chip_on) || (!load && active));
   assign do_read = awake && !do_write && (start || (!load && active));

   // Selected state and output drive permission
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_b_in)
      begin
         active <= 1'b0;
         drive <= 1'b0;
      end
      else if (clk_en_in)
      begin
         active <= awake && (start || (active && !load));
         drive <= do_read && active;
      end
   end

   // Upper address captured only on a load
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_b_in)
         addr_hi_reg <= '0;
      else if (clk_en_in && start)
         addr_hi_reg <= addr_in;
   end

   fbs_burst_ctr u_burst
   (
      .sys_clk_in(sys_clk_in),
      .rst_b_in(rst_b_in),
      .clk_en_in(clk_en_in),
      .load_in(start),
      .start_in(addr_in[1:0]),
      .step_in(step),
      .interleave_in(burst_order_in),
      .next_low_out(burst_next_low),
      .low_out(burst_low)
   );

   // Array address: new address on a load, else burst within the group
   assign mem_addr = start ? addr_in : {addr_hi_reg[ADDR_W-1:2], burst_next_low};

   // Pack data with parity into nine-bit lanes
   always_comb
   begin
      for (int i = 0; i < LANES; i++)
      begin
         wdata[i*fbs_pkg::LANE_BITS +: fbs_pkg::LANE_BITS] =
            {parity_io_in[i], dq_in[i*fbs_pkg::BYTE_BITS +: fbs_pkg::BYTE_BITS]};
      end
   end

   fbs_mem #(.ADDR_W(ADDR_W), .LANES(LANES)) u_mem
   (
      .sys_clk_in(sys_clk_in),
      .rst_b_in(rst_b_in),
      .clk_en_in(clk_en_in),
      .addr_in(mem_addr),
      .rd_en_in(do_read),
      .lane_we_in(do_write ? wr_mask : '0),
      .wdata_in(wdata),
      .rdata_out(rdata)
   );

   // Unpack read word onto data and parity outputs
   always_comb
   begin
      for (int i = 0; i < LANES; i++)
      begin
         dq_out[i*fbs_pkg::BYTE_BITS +: fbs_pkg::BYTE_BITS] =
            rdata[i*fbs_pkg::LANE_BITS +: fbs_pkg::BYTE_BITS];
         parity_io_out[i] = rdata[i*fbs_pkg::LANE_BITS + fbs_pkg::BYTE_BITS];
      end
   end

   // Asynchronous output enable gated by the registered drive permission
   assign dq_oe_out = drive && !output_enable_n_in;

   property p_first_read_masked;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (clk_en_in && do_read && !active) |=> !dq_oe_out;
   endproperty
   a_first_read_masked: assert property (p_first_read_masked)
      else $error("outputs driven on first read after deselect");
   property p_write_float;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (clk_en_in && do_write) |=> !dq_oe_out;
   endproperty
   a_write_float: assert property (p_write_float)
      else $error("outputs driven in write data phase");
   property p_proc_wins;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      proc_take |-> !ctrl_take;
   endproperty
   a_proc_wins: assert property (p_proc_wins)
      else $error("controller strobe taken with processor strobe");
   property p_proc_ignored;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      sel.sel1_n |-> !proc_take;
   endproperty
   a_proc_ignored: assert property (p_proc_ignored)
      else $error("processor strobe taken with primary select high");
   property p_proc_no_write;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      proc_take |-> !do_write;
   endproperty
   a_proc_no_write: assert property (p_proc_no_write)
      else $error("write on processor strobe edge");
   property p_global_all;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (do_write && !ctl.all_write_n) |-> (&wr_mask);
   endproperty
   a_global_all: assert property (p_global_all)
      else $error("global write missed a lane");
   property p_start_load;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (clk_en_in && start && $stable(burst_order_in)) |=>
         (burst_low == $past(addr_in[1:0]));
   endproperty
   a_start_load: assert property (p_start_load)
      else $error("burst start not loaded from address");
   property p_hold;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (clk_en_in && awake && active && !load && ctl.advance_n) ##1 $stable(burst_order_in)
         |-> $stable(burst_low);
   endproperty
   a_hold: assert property (p_hold)
      else $error("burst address moved without advance");
   property p_upper_fixed;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (clk_en_in && step) |=> $stable(addr_hi_reg);
   endproperty
   a_upper_fixed: assert property (p_upper_fixed)
      else $error("upper address changed during burst");
   property p_sleep_entry;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (awake && clk_en_in && sleep_request_in) ##1 (clk_en_in && sleep_request_in)
         |=> sleep_active_out;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry)
      else $error("sleep not entered after two clocks");

endmodule // fbs_port

`default_nettype wire

/* File: dv/fbs_host_model.sv */
// Controller-side model that drives the SRAM port bus pins
`default_nettype none

module fbs_host_model
(
   input wire logic sys_clk_in,
   input wire logic dq_oe_in,
   input wire logic [35:0] rd_in,
   output var fbs_pkg::fbs_ctl_t ctl_out,
   output var fbs_pkg::fbs_sel_t sel_out,
   output logic [7:0] addr_out,
   output logic [3:0] lane_n_out,
   output logic oe_n_out,
   output logic [35:0] wr_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic drv = 1'b0;
   logic [35:0] data = 36'h0;

   // Idle, deselected bus at time zero
   initial
   begin
      ctl_out = fbs_pkg::fbs_ctl_t'(5'h1F);
      sel_out = fbs_pkg::fbs_sel_t'(3'h0);
      addr_out = 8'h00;
      lane_n_out = 4'hF;
      oe_n_out = 1'b1;
   end

   // Data lines: host data, else device data, else a changing float pattern
   always_comb wr_out = drv ? data : (dq_oe_in ? rd_in : ~rd_in);

   // One bus cycle: change just after the edge, hold until the next
   task automatic cyc(input fbs_pkg::fbs_ctl_t c, input fbs_pkg::fbs_sel_t s,
                      input logic [7:0] a, input logic [3:0] ln, input logic [35:0] d,
                      input logic w, input logic o);
      @(posedge sys_clk_in);
      ctl_out <= c;
      sel_out <= s;
      addr_out <= a;
      lane_n_out <= ln;
      oe_n_out <= w | o;
      drv <= w;
      data <= d;
      #1;
   endtask
endmodule // fbs_host_model

`default_nettype wire

/* File: dv/fbs_port_tb.sv */
// Self-checking bench for the flow-through burst SRAM port
`default_nettype none

module fbs_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [4:0] IDLE = 5'h1F;
   localparam logic [4:0] CRD = 5'h17;
   localparam logic [4:0] CWR = 5'h15;
   localparam logic [4:0] PST = 5'h0D;
   localparam logic [4:0] PRD = 5'h0F;
   localparam logic [4:0] BURST_ADVANCE_N = 5'h1B;
   localparam logic [4:0] LWR = 5'h1E;
   localparam logic [4:0] GWR = 5'h1D;
   localparam logic [4:0] BOTH = 5'h05;
   localparam logic [2:0] SON = 3'h2;
   localparam logic [2:0] SOFF = 3'h0;
   localparam logic [2:0] S1HI = 3'h6;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic strap = 1'b1;
   logic sleep = 1'b0;
   logic ce = 1'b1;
   logic [35:0] wr;
   logic [35:0] rd;
   logic [35:0] mem [256];
   logic [35:0] pend_ed = 36'h0;
   logic pend_ck = 1'b0;
   logic pend_dr = 1'b0;
   logic dq_oe;
   logic sleep_act;
   fbs_pkg::fbs_ctl_t ctl;
   fbs_pkg::fbs_sel_t sel;
   logic [7:0] addr;
   logic [3:0] lane_n;
   logic oe_n;
   int err_count = 0;
   int check_count = 0;
   int cycles = 0;

   fbs_port #(.LANES(4), .ADDR_W(8)) fbs_port_inst (
      .sys_clk_in(sys_clk), .rst_b_in(rst_b), .clk_en_in(ce), .addr_in(addr),
      .processor_addr_strobe_n_in(ctl.proc_strobe_n),
      .controller_addr_strobe_n_in(ctl.ctrl_strobe_n),
      .burst_advance_n_in(ctl.advance_n), .chip_sel1_n_in(sel.sel1_n),
      .chip_sel2_in(sel.sel2), .chip_sel3_n_in(sel.sel3_n),
      .all_lanes_write_n_in(ctl.all_write_n), .lane_write_enable_n_in(ctl.lane_wr_en_n),
      .lane_select_n_in(lane_n), .output_enable_n_in(oe_n), .sleep_request_in(sleep),
      .burst_order_in(strap), .dq_in(wr[31:0]), .parity_io_in(wr[35:32]),
      .dq_out(rd[31:0]), .parity_io_out(rd[35:32]), .dq_oe_out(dq_oe),
      .sleep_active_out(sleep_act));

   fbs_host_model fbs_host_model_inst (
      .sys_clk_in(sys_clk), .dq_oe_in(dq_oe), .rd_in(rd), .ctl_out(ctl), .sel_out(sel),
      .addr_out(addr), .lane_n_out(lane_n), .oe_n_out(oe_n), .wr_out(wr));

   // Clock, 5 ns period
   initial forever #2.5 sys_clk = ~sys_clk;

   // Hang guard
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_count++;
         complete_run();
      end
   end

   // Expected low burst address bits
   function automatic logic [1:0] nxt(input logic [1:0] s, input logic [1:0] n);
      return strap ? (s ^ n) : 2'(s + n);
   endfunction

   // Expected word after a lane write
   function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] d,
                                         input logic [3:0] we);
      merge = o;
      for (int i = 0; i < 4; i++)
         if (we[i])
         begin
            merge[8*i+:8] = d[8*i+:8];
            merge[32+i] = d[32+i];
         end
   endfunction

   task automatic chk(input string n, input logic [35:0] e, input logic [35:0] s);
      check_count++;
      if (s !== e)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic complete_run();
      if (err_count == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // One cycle, then check the outcome of the cycle before it
   task automatic go(input logic [4:0] c, input logic [2:0] s, input logic [7:0] a,
                     input logic [3:0] ln, input logic [35:0] d, input logic w, input logic o,
                     input logic ck, input logic [35:0] ed, input logic dr);
      fbs_host_model_inst.cyc(fbs_pkg::fbs_ctl_t'(c), fbs_pkg::fbs_sel_t'(s), a, ln, d, w, o);
      if (pend_ck)
         chk("rdata", pend_ed, rd);
      chk("drive", {35'h0, pend_dr & ~oe_n}, {35'h0, dq_oe});
      pend_ck = ck;
      pend_ed = ed;
      pend_dr = dr;
   endtask

   // Deselect edge
   task automatic desel();
      go(CRD, SOFF, 8'($urandom), 4'hF, 36'h0, 1'b0, 1'b0, 1'b0, 36'h0, 1'b0);
   endtask

   // Fill a group of four with controller-started global writes
   task automatic wg(input logic [7:0] b);
      logic [35:0] d;
      for (int i = 0; i < 4; i++)
      begin
         d = {4'($urandom), 32'($urandom)};
         mem[b + 8'(i)] = d;
         go(CWR, SON, b + 8'(i), 4'($urandom), d, 1'b1, 1'b0, 1'b0, 36'h0, 1'b0);
      end
   endtask

   // Read burst after deselect, then hold and wrap
   task automatic rb(input logic [7:0] b, input logic [1:0] rs);
      logic [7:0] a;
      desel();
      a = {b[7:2], rs};
      go(CRD, SON, a, 4'hF, 36'h0, 1'b0, 1'b0, 1'b1, mem[a], 1'b0);
      for (int i = 1; i < 4; i++)
      begin
         a = {b[7:2], nxt(rs, 2'(i))};
         go(BURST_ADVANCE_N, SON, 8'($urandom), 4'hF, 36'h0, 1'b0, 1'($urandom), 1'b1, mem[a], 1'b1);
      end
      go(IDLE, SON, 8'($urandom), 4'hF, 36'h0, 1'b0, 1'b0, 1'b1, mem[a], 1'b1);
      a = {b[7:2], rs};
      go(BURST_ADVANCE_N, SON, 8'($urandom), 4'hF, 36'h0, 1'b0, 1'b0, 1'b1, mem[a], 1'b1);
   endtask

   // Processor-started write with junk write controls on the strobe edge
   task automatic pw(input logic [7:0] a, input logic g);
      logic [35:0] d;
      logic [3:0] ln;
      d = {4'($urandom), 32'($urandom)};
      ln = 4'($urandom) & 4'hE;
      desel();
      go(PST, SON, a, 4'h0, ~d, 1'b1, 1'b1, 1'b1, mem[a], 1'b0);
      go(g ? GWR : LWR, SON, a, ln, d, 1'b1, 1'b1, 1'b0, 36'h0, 1'b0);
      mem[a] = merge(mem[a], d, g ? 4'hF : ~ln);
      go(IDLE, SON, a, 4'hF, 36'h0, 1'b0, 1'b0, 1'b1, mem[a], 1'b1);
   endtask

   // Sleep entry and exit, then contents read back
   task automatic zz(input logic [7:0] b);
      desel();
      go(IDLE, SOFF, b, 4'hF, 36'h0, 1'b0, 1'b0, 1'b0, 36'h0, 1'b0);
      @(posedge sys_clk);
      sleep <= 1'b1;
      ce <= 1'b0;
      repeat (3) @(posedge sys_clk);
      ce <= 1'b1;
      #1;
      chk("frozen", 36'h0, {35'h0, sleep_act});
      @(posedge sys_clk);
      #1;
      chk("sleep", 36'h0, {35'h0, sleep_act});
      @(posedge sys_clk);
      #1;
      chk("sleep", 36'h1, {35'h0, sleep_act});
      repeat (4) @(posedge sys_clk);
      sleep <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk("sleep", 36'h1, {35'h0, sleep_act});
      @(posedge sys_clk);
      #1;
      chk("sleep", 36'h0, {35'h0, sleep_act});
      rb(b, 2'h1);
      desel();
   endtask

   // Main sequence, linear then interleaved order
   initial
   begin
      logic [7:0] b;
      logic [7:0] a;
      logic [1:0] rs;
      void'($urandom(23));
      for (int m = 0; m < 2; m++)
      begin
         rst_b <= 1'b0;
         strap <= 1'(m);
         repeat (4) @(posedge sys_clk);
         rst_b <= 1'b1;
         pend_ck = 1'b0;
         pend_dr = 1'b0;
         for (int k = 0; k < 6; k++)
         begin
            b = {6'($urandom), 2'h0};
            rs = 2'($urandom);
            wg(b);
            rb(b, rs);
            a = {b[7:2], rs};
            go(PRD, S1HI, 8'($urandom), 4'hF, 36'h0, 1'b0, 1'b0, 1'b1, mem[a], 1'b1);
            pw({b[7:2], 2'($urandom)}, k[0]);
            a = {b[7:2], 2'($urandom)};
            desel();
            go(BOTH, SON, a, 4'h0, ~mem[a], 1'b1, 1'b1, 1'b1, mem[a], 1'b0);
            go(IDLE, SON, a, 4'hF, 36'h0, 1'b0, 1'b0, 1'b1, mem[a], 1'b1);
         end
         zz(b);
      end
      complete_run();
   end
endmodule // fbs_port_tb

`default_nettype wire
